// ### rtl/cbt_pkg.sv
// shared constants and types for the can bit timing and acceptance block
package cbt_pkg;

  // system clock rate; one time quantum is one prescaled clock period
  localparam int unsigned SYS_CLK_HZ   = 50_000_000;

  // register indices; the wishbone byte address is four times the index
  localparam logic [5:0]  IDX_TX_CTRL  = 6'h30;
  localparam logic [5:0]  IDX_BTC1     = 6'h31;
  localparam logic [5:0]  IDX_BTC2     = 6'h32;
  localparam logic [5:0]  IDX_CODE_SH  = 6'h33;
  localparam logic [5:0]  IDX_CODE_SL  = 6'h34;
  localparam logic [5:0]  IDX_CODE_EH  = 6'h35;
  localparam logic [5:0]  IDX_CODE_EM  = 6'h36;
  localparam logic [5:0]  IDX_CODE_EL  = 6'h37;
  localparam logic [5:0]  IDX_MASK_SH  = 6'h38;
  localparam logic [5:0]  IDX_MASK_SL  = 6'h39;
  localparam logic [5:0]  IDX_MASK_EH  = 6'h3a;
  localparam logic [5:0]  IDX_MASK_EM  = 6'h3b;
  localparam logic [5:0]  IDX_MASK_EL  = 6'h3c;
  localparam logic [5:0]  IDX_RX_CTRL  = 6'h3d;
  localparam logic [5:0]  IDX_TX_ABORT = 6'h3e;
  localparam logic [5:0]  IDX_STATUS   = 6'h3f;
  localparam int          REG_COUNT    = 15;

  // reset values
  localparam logic [7:0]  RST_TX_CTRL  = 8'h02;
  localparam logic [7:0]  RST_ZERO     = 8'h00;

  // field positions
  localparam int          PRESC_LSB    = 0;
  localparam int          PROP_LSB     = 4;
  localparam int          PH1_LSB      = 0;
  localparam int          PH2_LSB      = 3;
  localparam int          SLEEP_BIT    = 0;

  // implemented bits per register, unused bits read zero
  localparam logic [7:0]  WM_BTC1      = 8'h7f;
  localparam logic [7:0]  WM_BTC2      = 8'h3f;
  localparam logic [7:0]  WM_ID_HIGH   = 8'h1f;
  localparam logic [7:0]  WM_ID_LOW    = 8'hfc;
  localparam logic [7:0]  WM_EXT_HIGH  = 8'h0f;
  localparam logic [7:0]  WM_FULL      = 8'hff;

  typedef enum logic [1:0] {SEG_SYNC, SEG_PROP, SEG_PH1, SEG_PH2} cbt_seg_t;

  typedef struct packed {
    logic [3:0] presc;
    logic [2:0] prop;
    logic [2:0] ph1;
    logic [2:0] ph2;
  } cbt_timing_t;

  typedef struct packed {
    logic        ext;
    logic [10:0] std_id;
    logic [17:0] ext_id;
  } cbt_id_t;

  typedef struct packed {
    logic [2:0] zero;
    logic       accept;
    logic       ext;
    cbt_seg_t   seg;
    logic       sleep;
  } cbt_status_t;

endpackage

// ### rtl/cbt_bit_timer.sv
// prescaler and bit time segment sequencer
module cbt_bit_timer
  import cbt_pkg::*;
(
  input  wire logic  clk,
  input  wire logic  rst_b,
  input  cbt_timing_t cfg,
  input  wire logic  run,
  output logic       tq_tick_q,
  output logic       bit_start_q,
  output logic       sample_pt_q,
  output cbt_seg_t   seg_q
);

  logic [3:0] pre_q;
  logic [3:0] pre_d;
  logic [2:0] tq_q;
  logic [2:0] tq_d;
  cbt_seg_t   seg_d;

  // programmed length minus one; sync is always a single quantum
  function automatic logic [2:0] seg_len(input cbt_seg_t s, input cbt_timing_t c);
    unique case (s)
      SEG_SYNC: seg_len = 3'h0;
      SEG_PROP: seg_len = c.prop;
      SEG_PH1:  seg_len = c.ph1;
      SEG_PH2:  seg_len = c.ph2;
    endcase
  endfunction

  function automatic cbt_seg_t seg_next(input cbt_seg_t s);
    unique case (s)
      SEG_SYNC: seg_next = SEG_PROP;
      SEG_PROP: seg_next = SEG_PH1;
      SEG_PH1:  seg_next = SEG_PH2;
      SEG_PH2:  seg_next = SEG_SYNC;
    endcase
  endfunction

  // divide by presc plus one; lowering presc mid count wraps once through 15
  wire tick    = run && (pre_q == cfg.presc);
  wire seg_end = tick && (tq_q == seg_len(seg_q, cfg));
  assign pre_d = (!run || tick) ? 4'h0 : pre_q + 4'h1;
  assign tq_d  = (!run || seg_end) ? 3'h0 : (tick ? tq_q + 3'h1 : tq_q);
  assign seg_d = !run ? SEG_SYNC : (seg_end ? seg_next(seg_q) : seg_q);

  // counters, segment state and registered pulses
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      pre_q       <= 4'h0;
      tq_q        <= 3'h0;
      seg_q       <= SEG_SYNC;
      tq_tick_q   <= 1'b0;
      bit_start_q <= 1'b0;
      sample_pt_q <= 1'b0;
    end
    else
    begin
      pre_q       <= pre_d;
      tq_q        <= tq_d;
      seg_q       <= seg_d;
      tq_tick_q   <= tick;
      bit_start_q <= seg_end && (seg_q == SEG_PH2);
      sample_pt_q <= seg_end && (seg_q == SEG_PH1);
    end
  end

  // helper: cycles since the last quantum tick, valid once presc held steady
  logic [4:0] gap_q;
  logic [3:0] presc_prev_q;
  logic       gap_ok_q;
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      gap_q        <= 5'h00;
      presc_prev_q <= 4'h0;
      gap_ok_q     <= 1'b0;
    end
    else
    begin
      gap_q        <= tick ? 5'h00 : gap_q + {4'h0, (gap_q != 5'h1f)};
      presc_prev_q <= cfg.presc;
      gap_ok_q     <= (!run || cfg.presc != presc_prev_q) ? 1'b0 : (tick ? 1'b1 : gap_ok_q);
    end
  end

  presc_period_a: assert property (@(posedge clk) disable iff (!rst_b)
    (tick && gap_ok_q && cfg.presc == presc_prev_q) |-> (gap_q == {1'b0, cfg.presc}))
    else $error("quantum period differs from prescaler plus one");

  sync_one_tq_a: assert property (@(posedge clk) disable iff (!rst_b)
    (tick && seg_q == SEG_SYNC) |=> (!run || seg_q == SEG_PROP))
    else $error("sync segment did not last one quantum");

endmodule

// ### rtl/cbt_top.sv
// can bit timing, prescaler and acceptance filter with wishbone registers
//
// The implementer's own choice: the Wishbone register port.
module cbt_top
  import cbt_pkg::*;
(
  input  wire logic        CLK,
  input  wire logic        RST_B,
  input  wire logic        WB_CYC_I,
  input  wire logic        WB_STB_I,
  input  wire logic        WB_WE_I,
  input  wire logic [3:0]  WB_SEL_I,
  input  wire logic [7:0]  WB_ADR_I,
  input  wire logic [31:0] WB_DAT_I,
  output logic      [31:0] WB_DAT_O,
  output logic             WB_ACK_O,
  input  wire logic        ID_VALID,
  input  cbt_id_t          ID_IN,
  output logic             ID_DONE,
  output logic             ID_ACCEPT,
  output logic             TQ_TICK,
  output logic             BIT_START,
  output logic             SAMPLE_POINT,
  output cbt_seg_t         SEGMENT
);

  logic [7:0]  regs_q [REG_COUNT];
  logic [31:0] dat_q;
  logic        ack_q;
  logic        done_q;
  logic        accept_q;
  logic        last_ext_q;

  // implemented bits of each register
  function automatic logic [7:0] wmask(input logic [5:0] idx);
    unique case (idx)
      IDX_BTC1:                 wmask = WM_BTC1;
      IDX_BTC2:                 wmask = WM_BTC2;
      IDX_CODE_SH, IDX_MASK_SH: wmask = WM_ID_HIGH;
      IDX_CODE_SL, IDX_MASK_SL: wmask = WM_ID_LOW;
      IDX_CODE_EH, IDX_MASK_EH: wmask = WM_EXT_HIGH;
      IDX_CODE_EL, IDX_MASK_EL: wmask = WM_ID_LOW;
      default:                  wmask = WM_FULL;
    endcase
  endfunction

  // reset value of each register
  function automatic logic [7:0] rst_val(input logic [5:0] idx);
    rst_val = (idx == IDX_TX_CTRL) ? RST_TX_CTRL : RST_ZERO;
  endfunction

  // a bit mismatches only where its mask bit asks for comparison
  function automatic logic id_match(input logic [17:0] id, input logic [17:0] code,
                                    input logic [17:0] mask);
    id_match = (((id ^ code) & mask) == 18'h00000);
  endfunction

  function automatic logic [5:0] idx_of(input int i);
    idx_of = IDX_TX_CTRL + 6'(i);
  endfunction

  // bus decode; the registers hold one byte each in lane zero
  wire       req      = WB_CYC_I && WB_STB_I && !ack_q;
  wire [5:0] idx      = WB_ADR_I[7:2];
  wire       in_map   = (idx >= IDX_TX_CTRL) && (idx <= IDX_TX_ABORT);
  wire       is_stat  = (idx == IDX_STATUS);
  wire [3:0] off      = 4'(idx - IDX_TX_CTRL);
  wire       sleep    = regs_q[0][SLEEP_BIT];
  // while asleep only the transmit control register may be written to wake
  wire       wr_allow = !sleep || (idx == IDX_TX_CTRL);
  wire       wr_en    = req && WB_WE_I && WB_SEL_I[0] && in_map && wr_allow;

  // timing configuration taken from the two timing registers
  cbt_timing_t cfg;
  assign cfg.presc = regs_q[1][PRESC_LSB +: 4];
  assign cfg.prop  = regs_q[1][PROP_LSB +: 3];
  assign cfg.ph1   = regs_q[2][PH1_LSB +: 3];
  assign cfg.ph2   = regs_q[2][PH2_LSB +: 3];

  // filter code and mask words gathered from the byte registers
  wire [10:0] std_code = {regs_q[3][4:0], regs_q[4][7:2]};
  wire [17:0] ext_code = {regs_q[5][3:0], regs_q[6], regs_q[7][7:2]};
  wire [10:0] std_mask = {regs_q[8][4:0], regs_q[9][7:2]};
  wire [17:0] ext_mask = {regs_q[10][3:0], regs_q[11], regs_q[12][7:2]};

  wire std_ok = id_match({7'h00, ID_IN.std_id}, {7'h00, std_code}, {7'h00, std_mask});
  wire ext_ok = id_match(ID_IN.ext_id, ext_code, ext_mask);
  // standard frames ignore the extended part of the filter
  wire accept_w = std_ok && (!ID_IN.ext || ext_ok);

  // status readback shows the block's own state
  cbt_status_t status;
  assign status.zero   = 3'h0;
  assign status.accept = accept_q;
  assign status.ext    = last_ext_q;
  assign status.seg    = SEGMENT;
  assign status.sleep  = sleep;

  wire [31:0] rd_w = in_map  ? {24'h000000, regs_q[off]} :
                     is_stat ? {24'h000000, status} : 32'h00000000;

  // register file; unused bits are never stored so they read zero
  always_ff @(posedge CLK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      for (int i = 0; i < REG_COUNT; i++)
      begin
        regs_q[i] <= rst_val(idx_of(i));
      end
    end
    else
    begin
      for (int i = 0; i < REG_COUNT; i++)
      begin
        if (wr_en && off == 4'(i))
        begin
          regs_q[i] <= WB_DAT_I[7:0] & wmask(idx_of(i));
        end
      end
    end
  end

  // single-cycle wishbone answer; unmapped reads give zero, writes vanish
  always_ff @(posedge CLK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      ack_q <= 1'b0;
      dat_q <= 32'h00000000;
    end
    else
    begin
      ack_q <= req;
      dat_q <= req ? rd_w : dat_q;
    end
  end

  // filter result: one-cycle done pulse, accept held until the next identifier
  always_ff @(posedge CLK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      done_q     <= 1'b0;
      accept_q   <= 1'b0;
      last_ext_q <= 1'b0;
    end
    else
    begin
      done_q     <= ID_VALID;
      accept_q   <= ID_VALID ? accept_w : accept_q;
      last_ext_q <= ID_VALID ? ID_IN.ext : last_ext_q;
    end
  end

  assign WB_ACK_O  = ack_q;
  assign WB_DAT_O  = dat_q;
  assign ID_DONE   = done_q;
  assign ID_ACCEPT = accept_q;

  // the quantum clock halts while asleep so the bit timer stays in sync
  cbt_bit_timer u_timer (
    .clk         (CLK),
    .rst_b       (RST_B),
    .cfg         (cfg),
    .run         (!sleep),
    .tq_tick_q   (TQ_TICK),
    .bit_start_q (BIT_START),
    .sample_pt_q (SAMPLE_POINT),
    .seg_q       (SEGMENT)
  );

  // bus handshake sequences
  sequence wb_req_s;
    WB_CYC_I && WB_STB_I && !WB_ACK_O;
  endsequence

  sequence wb_ack_s;
    WB_ACK_O ##1 !WB_ACK_O;
  endsequence

  ack_timing_a: assert property (@(posedge CLK) disable iff (!RST_B)
    wb_req_s |=> wb_ack_s)
    else $error("wishbone ack not a single pulse one cycle after request");

  read_back_a: assert property (@(posedge CLK) disable iff (!RST_B)
    (wb_req_s and (!WB_WE_I && in_map)) |=> (WB_DAT_O[7:0] == $past(regs_q[off])))
    else $error("read data does not match register contents");

  unmapped_zero_a: assert property (@(posedge CLK) disable iff (!RST_B)
    (wb_req_s and (!in_map && !is_stat)) |=> (WB_ACK_O && WB_DAT_O == 32'h00000000))
    else $error("unmapped access not answered with zero");

  timing_write_a: assert property (@(posedge CLK) disable iff (!RST_B)
    (wr_en && idx == IDX_BTC1) |=> (cfg.presc == $past(WB_DAT_I[3:0])
                                    && cfg.prop == $past(WB_DAT_I[6:4])))
    else $error("timing register write did not reach the timer");

  sleep_guard_a: assert property (@(posedge CLK) disable iff (!RST_B)
    (wb_req_s and (WB_WE_I && sleep && in_map && idx != IDX_TX_CTRL))
      |=> (regs_q[$past(off)] == $past(regs_q[off])))
    else $error("register changed by a write during sleep");

  reset_vals_a: assert property (@(posedge CLK)
    $rose(RST_B) |-> (regs_q[0] == RST_TX_CTRL && regs_q[1] == RST_ZERO
                      && regs_q[2] == RST_ZERO && regs_q[13] == RST_ZERO
                      && regs_q[14] == RST_ZERO))
    else $error("register reset value wrong");

  std_accept_a: assert property (@(posedge CLK) disable iff (!RST_B)
    (ID_VALID && !ID_IN.ext) |=> (ID_DONE
      && ID_ACCEPT == ($past((ID_IN.std_id & std_mask) == (std_code & std_mask)))))
    else $error("standard identifier filter result wrong");

  ext_accept_a: assert property (@(posedge CLK) disable iff (!RST_B)
    (ID_VALID && ID_IN.ext && ((ID_IN.ext_id ^ ext_code) & ext_mask) != 18'h00000)
      |=> (ID_DONE && !ID_ACCEPT))
    else $error("extended identifier accepted despite mismatch");

  sample_order_a: assert property (@(posedge CLK) disable iff (!RST_B)
    SAMPLE_POINT |-> (SEGMENT == SEG_PH2 || sleep))
    else $error("sample point not followed by second phase segment");

endmodule

// ### verif/cbt_node_model.sv
// behavioural remote node that hands received identifiers to the filter
module cbt_node_model
  import cbt_pkg::*;
(
  input  wire logic clk,
  input  wire logic send,
  input  cbt_id_t   frame_id,
  output logic      id_valid,
  output cbt_id_t   id_out
);
  // quiet lines at time zero
  initial
  begin
    id_valid = 1'h0;
    id_out   = '0;
  end

  // one identifier per request; idle lines toggle so stale ids never look valid
  always @(posedge clk)
  begin
    id_valid <= send;
    id_out   <= send ? frame_id : ~id_out;
  end
endmodule

// ### verif/tb_can_bit_timing_acceptance.sv
// self-checking bench for timing registers, quantum sequencer and id filter
module tb_can_bit_timing_acceptance
  import cbt_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  typedef struct packed {logic [5:0] i; logic [7:0] r, w, e;} cbt_reg_row_t;
  typedef struct packed {cbt_id_t id; logic e;} cbt_id_row_t;

  // index, reset value, write value, read back
  localparam cbt_reg_row_t REGS [17] = '{
    '{6'h30, 8'h02, 8'hfe, 8'hfe}, '{6'h31, 8'h00, 8'hff, 8'h7f},
    '{6'h32, 8'h00, 8'hff, 8'h3f}, '{6'h33, 8'h00, 8'hff, 8'h1f},
    '{6'h34, 8'h00, 8'hff, 8'hfc}, '{6'h35, 8'h00, 8'hff, 8'h0f},
    '{6'h36, 8'h00, 8'hff, 8'hff}, '{6'h37, 8'h00, 8'hff, 8'hfc},
    '{6'h38, 8'h00, 8'hff, 8'h1f}, '{6'h39, 8'h00, 8'hff, 8'hfc},
    '{6'h3a, 8'h00, 8'hff, 8'h0f}, '{6'h3b, 8'h00, 8'hff, 8'hff},
    '{6'h3c, 8'h00, 8'hff, 8'hfc}, '{6'h3d, 8'h00, 8'hff, 8'hff},
    '{6'h3e, 8'h00, 8'hff, 8'hff}, '{6'h00, 8'h00, 8'hff, 8'h00},
    '{6'h2f, 8'h00, 8'hff, 8'h00}};
  localparam cbt_id_t CODE = '{1'h0, 11'h5a3, 18'h2b4c1};
  // identifier and whether it must pass with a full mask
  localparam cbt_id_row_t IDS [6] = '{
    '{'{1'h0, 11'h5a3, 18'h00000}, 1'h1}, '{'{1'h0, 11'h5a2, 18'h2b4c1}, 1'h0},
    '{'{1'h1, 11'h5a3, 18'h2b4c1}, 1'h1}, '{'{1'h1, 11'h5a3, 18'h0b4c1}, 1'h0},
    '{'{1'h1, 11'h1a3, 18'h2b4c1}, 1'h0}, '{'{1'h1, 11'h5a3, 18'h2b4c0}, 1'h0}};

  logic        clk, rst_b, cyc, stb, we, ack, send, id_valid, id_done, id_acc, tq, bs, sp;
  logic [3:0]  sel;
  logic [7:0]  adr;
  logic [31:0] wdat, rdat, q;
  cbt_id_t     frame, id_bus;
  cbt_seg_t    seg;
  int          miscompares, n_tests, n;

  cbt_top i_dut (.CLK(clk), .RST_B(rst_b), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we),
    .WB_SEL_I(sel), .WB_ADR_I(adr), .WB_DAT_I(wdat), .WB_DAT_O(rdat), .WB_ACK_O(ack),
    .ID_VALID(id_valid), .ID_IN(id_bus), .ID_DONE(id_done), .ID_ACCEPT(id_acc),
    .TQ_TICK(tq), .BIT_START(bs), .SAMPLE_POINT(sp), .SEGMENT(seg));
  cbt_node_model i_node (.clk(clk), .send(send), .frame_id(frame), .id_valid(id_valid),
    .id_out(id_bus));

  // 50 MHz system clock
  always #10 clk = ~clk;

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_tests++;
    if (got !== exp)
    begin
      miscompares++;
      $display("CHECK FAILED t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic complete_run();
    $display("checks %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // classic single cycle; held until ack is sampled high, only the watchdog ends a wait
  task automatic wb(input logic w, input logic [5:0] i, input logic [7:0] d,
                    input logic [3:0] s, output logic [31:0] r);
    @(posedge clk);
    cyc  <= 1'h1;
    stb  <= 1'h1;
    we   <= w;
    sel  <= s;
    adr  <= {i, 2'h0};
    wdat <= {24'h000000, d};
    do @(posedge clk); while (ack !== 1'h1);
    r = rdat;
    cyc <= 1'h0;
    stb <= 1'h0;
  endtask

  task automatic wr(input logic [5:0] i, input logic [7:0] d);
    logic [31:0] r;
    wb(1'h1, i, d, 4'hf, r);
  endtask

  // whole word compared so the upper lanes must read zero
  task automatic rd_chk(input logic [5:0] i, input logic [7:0] e, input string m);
    logic [31:0] r;
    wb(1'h0, i, 8'h00, 4'hf, r);
    chk(r, {24'h000000, e}, m);
  endtask

  function automatic logic [39:0] id_bytes(input cbt_id_t v);
    return {3'h0, v.std_id[10:6], v.std_id[5:0], 2'h0, 4'h0, v.ext_id[17:14],
            v.ext_id[13:6], v.ext_id[5:0], 2'h0};
  endfunction

  task automatic set_filter(input cbt_id_t c, input cbt_id_t m);
    logic [39:0] cb, mb;
    cb = id_bytes(c);
    mb = id_bytes(m);
    for (int k = 0; k < 5; k++)
    begin
      wr(6'h33 + 6'(k), cb[39-8*k -: 8]);
      wr(6'h38 + 6'(k), mb[39-8*k -: 8]);
    end
  endtask

  // node presents the id one edge after send, the result stands one edge later
  task automatic id_chk(input cbt_id_t id, input logic e);
    @(posedge clk);
    send  <= 1'h1;
    frame <= id;
    @(posedge clk);
    send <= 1'h0;
    repeat (2) @(posedge clk);
    chk(id_done, 1'h1, "filter done");
    chk(id_acc, e, "filter result");
    @(posedge clk);
    chk(id_done, 1'h0, "done lasts one cycle");
  endtask

  task automatic wait_bs();
    int k;
    k = 0;
    do @(posedge clk); while (bs !== 1'h1 && k++ < 2000);
    chk(bs, 1'h1, "bit start seen");
  endtask

  // two bit starts first: a prescaler change may wrap once mid-quantum
  task automatic timer_chk(input logic [3:0] p, input logic [2:0] a, input logic [2:0] b,
                           input logic [2:0] c);
    int k, ts, tq1, qn;
    cbt_seg_t sg;
    k = 0;
    ts = 0;
    tq1 = 0;
    sg = SEG_SYNC;
    qn = p + 1;
    wr(6'h31, {1'h0, a, p});
    wr(6'h32, {2'h0, c, b});
    wait_bs();
    wait_bs();
    do
    begin
      @(posedge clk);
      k++;
      if (sp === 1'h1)
      begin
        ts = k;
        sg = seg;
      end
      if (tq === 1'h1 && tq1 == 0)
        tq1 = k;
    end
    while (bs !== 1'h1 && k < 2000);
    chk(k, qn * (4 + a + b + c), "bit length");
    chk(ts, qn * (3 + a + b), "sample point");
    chk(sg, SEG_PH2, "segment at sample point");
    chk(tq1, qn, "quantum length");
  endtask

  // watchdog against a hung handshake
  initial
  begin
    repeat (20000) @(posedge clk);
    miscompares++;
    complete_run();
  end

  initial
  begin
    clk = 1'h0; rst_b = 1'h0; cyc = 1'h0; stb = 1'h0; we = 1'h0; sel = 4'h0;
    adr = 8'h00; wdat = 32'h0; send = 1'h0; frame = '0;
    miscompares = 0;
    n_tests = 0;
    repeat (20) @(posedge clk);
    rst_b <= 1'h1;
    foreach (REGS[k])
    begin
      rd_chk(REGS[k].i, REGS[k].r, "reset value");
      wr(REGS[k].i, REGS[k].w);
      rd_chk(REGS[k].i, REGS[k].e, "read back");
    end
    set_filter(CODE, '{1'h0, 11'h7ff, 18'h3ffff});
    foreach (IDS[k])
      id_chk(IDS[k].id, IDS[k].e);
    // hand cases: one masked bit, then an open mask
    set_filter(CODE, '{1'h0, 11'h7fe, 18'h3ffff});
    id_chk('{1'h0, 11'h5a2, 18'h00000}, 1'h1);
    set_filter(CODE, '0);
    id_chk('{1'h1, 11'h000, 18'h00000}, 1'h1);
    // every bit kept between 8 and 25 quanta, as software must
    timer_chk(4'h2, 3'h1, 3'h0, 3'h3);
    timer_chk(4'hf, 3'h7, 3'h7, 3'h7);
    timer_chk(4'h0, 3'h2, 3'h1, 3'h1);
    // sleep stops the sequencer and locks the other registers
    wr(6'h30, 8'h03);
    n = 0;
    repeat (20) @(posedge clk) if (tq !== 1'h0) n++;
    chk(n, 0, "ticks while asleep");
    chk(seg, SEG_SYNC, "segment while asleep");
    wr(6'h31, 8'h55);
    wr(6'h3f, 8'hff);
    rd_chk(6'h31, 8'h20, "locked while asleep");
    rd_chk(6'h3f, 8'h19, "status");
    wr(6'h30, 8'h02);
    wb(1'h1, 6'h31, 8'h55, 4'he, q);
    rd_chk(6'h31, 8'h20, "byte lane off");
    // second reset in mid-run
    @(posedge clk);
    rst_b <= 1'h0;
    repeat (3) @(posedge clk);
    chk(seg, SEG_SYNC, "segment in reset");
    chk(id_acc, 1'h0, "accept in reset");
    rst_b <= 1'h1;
    foreach (REGS[k])
      rd_chk(REGS[k].i, REGS[k].r, "value after reset");
    complete_run();
  end
endmodule
